// ---- tbp_bus_sink.sv ----
`timescale 1ns/1ps
module tbp_bus_sink (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // Telecom bus
   input  wire logic        bus_clock_i,
   input  wire logic [11:0] bus_i,
   // Captured byte and its place since the bus started
   output logic             stb_o,
   output logic [15:0]      idx_o,
   output logic [11:0]      cap_o
);
   logic       prev;
   logic [1:0] low;
   // A bus clock parked low for two cycles or more marks a restart of the frame
   always_ff @(posedge clk_i) begin
      prev <= bus_clock_i;
      stb_o <= 1'b0;
      if (!rst_n_i) begin
         low <= 2'h2;
         idx_o <= 16'h0000;
      end else if (!bus_clock_i) begin
         low <= (low == 2'h2) ? 2'h2 : low + 2'h1;
      end else if (!prev) begin
         stb_o <= 1'b1;
         cap_o <= bus_i;
         idx_o <= (low > 2'h1) ? 16'h0000 : idx_o + 16'h0001;
         low <= 2'h0;
      end
   end
endmodule

// ---- tbp_defines.svh ----
`ifndef TBP_DEFINES_SVH
`define TBP_DEFINES_SVH

// Register indices; byte address is four times the index
`define TBP_IDX_SYNC_DLY     10'h0135
`define TBP_IDX_CTRL         10'h0137
`define TBP_IDX_STATUS       10'h0130

// Control register fields
`define TBP_CTRL_ENABLE      0
`define TBP_CTRL_REPHASE_DIS 1
`define TBP_CTRL_PAR_ODD     2
`define TBP_CTRL_PAR_WIDE    3
`define TBP_CTRL_EXT_SYNC    4
`define TBP_CTRL_AIS_LSB     5
`define TBP_CTRL_RESET       8'h00
`define TBP_SYNC_DLY_RESET   8'h00

// Status register fields
`define TBP_STAT_UNDERFLOW   0
`define TBP_STAT_ROW_LSB     8
`define TBP_STAT_COL_LSB     16

// Frame geometry of an STS-3 frame, one byte per bus clock
`define TBP_ROWS             4'h9
`define TBP_COLS             9'h10E
`define TBP_TOH_COLS         9'h009
`define TBP_SLOTS            2'h3
`define TBP_J0_COL           9'h006
`define TBP_J1_ROW           4'h3
`define TBP_J1_COL_LAST      9'h00B

// Transport overhead pattern bytes
`define TBP_A1_BYTE          8'hF6
`define TBP_A2_BYTE          8'h28
`define TBP_J0_BYTE          8'h01
`define TBP_A2_COL           9'h003

// Timing: bus byte period and the system clock
`define TBP_CLK_NS           50
`define TBP_BUS_NS           100
`define TBP_CLKS_PER_HALF    ((`TBP_BUS_NS / `TBP_CLK_NS) / 2)

// AXI responses
`define TBP_RESP_OKAY        2'h0
`define TBP_RESP_SLVERR      2'h2

`endif

// ---- tbp_pkg.sv ----
package tbp_pkg;
   typedef logic [7:0]  tbp_byte_t;
   typedef logic [3:0]  tbp_row_t;
   typedef logic [8:0]  tbp_col_t;
   typedef logic [1:0]  tbp_slot_t;
   typedef logic [31:0] tbp_word_t;
endpackage

// ---- tbp_two_buf.sv ----
`timescale 1ns/1ps
module tbp_two_buf (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   // Filling side
   input  wire logic             s_valid_i,
   output logic                  s_ready_o,
   input  wire tbp_pkg::tbp_byte_t s_data_i,
   // Draining side
   output logic                  m_valid_o,
   input  wire logic             m_ready_i,
   output tbp_pkg::tbp_byte_t    m_data_o
);
   tbp_pkg::tbp_byte_t mem [2];
   logic               wr_ptr;
   logic               rd_ptr;
   logic [1:0]         count;
   logic               push;
   logic               pop;
   logic [1:0]         next_count;

   assign push       = s_valid_i & s_ready_o;
   assign pop        = m_valid_o & m_ready_i;
   assign next_count = count + {1'b0, push} - {1'b0, pop};
   assign m_data_o   = mem[rd_ptr];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= s_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wr_ptr    <= 1'b0;
         rd_ptr    <= 1'b0;
         count     <= 2'h0;
         s_ready_o <= 1'b1;
         m_valid_o <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         count     <= next_count;
         // Ready from a flop so the source sees honest back-pressure
         s_ready_o <= (next_count != 2'h2);
         m_valid_o <= (next_count != 2'h0);
      end
   end
endmodule

// ---- tbp_tx_bus_port.sv ----
// Contract
// R1: Bus clock is made on-chip and times every transmit bus output.
// R2: Every bus output changes only at a rising bus clock edge; the code clears them at the next clk_i edge after a disable, mid-period.
// R3: Marker pulses one byte on the C1/J0 byte with payload flag low.
// R4: Marker pulses one byte on each J1 byte with payload flag high.
// R5: Marker is driven only when enabled and rephase-disabled mode is selected.
// R6: Alarm flag is high on bytes of an STS-1 carrying AIS-P, else low; the code raises it on payload bytes only, never on overhead bytes.
// R7: Alarm flag is driven only when enabled and in rephase-disabled mode.
// R8: Parity is even or odd, over data alone or data, payload flag, marker.
// R9: Parity sense and coverage come from the bus control register.
// R10: With external alignment, a sync rising edge starts a new frame.
// R11: With sync held low, frames run on the port's own timing.
// R12: Sync source gives one-clock-wide pulses at 8 kHz, never a square wave.
// R13: Sync source keeps its pulse synchronous with the reference clock.
// R14: Sync-to-frame delay comes from the frame sync delay register.
// R15: Payload flag is low on overhead bytes and high on payload bytes.
// R16: When enabled, each frame byte goes out on eight lines per bus clock.
// R17: Marker and alarm flag are held low when disabled or not rephase-disabled.
`timescale 1ns/1ps
`include "tbp_defines.svh"
module tbp_tx_bus_port (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   // AXI4-Lite write address
   input  wire logic [11:0]         s_axi_awaddr_i,
   input  wire logic                s_axi_awvalid_i,
   output logic                     s_axi_awready_o,
   // AXI4-Lite write data
   input  wire logic [31:0]         s_axi_wdata_i,
   input  wire logic [3:0]          s_axi_wstrb_i,
   input  wire logic                s_axi_wvalid_i,
   output logic                     s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0]               s_axi_bresp_o,
   output logic                     s_axi_bvalid_o,
   input  wire logic                s_axi_bready_i,
   // AXI4-Lite read address
   input  wire logic [11:0]         s_axi_araddr_i,
   input  wire logic                s_axi_arvalid_i,
   output logic                     s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0]              s_axi_rdata_o,
   output logic [1:0]               s_axi_rresp_o,
   output logic                     s_axi_rvalid_o,
   input  wire logic                s_axi_rready_i,
   // Payload byte stream in
   input  wire tbp_pkg::tbp_byte_t  pay_data_i,
   input  wire logic                pay_valid_i,
   output logic                     pay_ready_o,
   // Frame sync pin
   input  wire logic                tx_frame_sync_in_i,
   // Transmit telecom bus
   output logic                     tx_bus_clock_o,
   output tbp_pkg::tbp_byte_t       tx_bus_byte_o,
   output logic                     tx_payload_flag_o,
   output logic                     tx_phase_marker_o,
   output logic                     tx_path_alarm_flag_o,
   output logic                     tx_bus_parity_o
);
   tbp_pkg::tbp_byte_t frame_sync_delay_setting;
   tbp_pkg::tbp_byte_t bus_port_control;
   logic               underflow;
   tbp_pkg::tbp_row_t  row;
   tbp_pkg::tbp_col_t  col;
   tbp_pkg::tbp_slot_t slot;
   logic               sync_ff1;
   logic               sync_ff2;
   logic               sync_last;
   logic               sync_edge;
   logic               sync_pend;
   tbp_pkg::tbp_byte_t dly_cnt;
   logic               restart;
   logic               bus_rise;
   logic               port_en;
   logic               rephase_disabled_mode;
   logic               is_toh;
   logic               is_c1;
   logic               is_j1;
   logic               buf_valid;
   logic               buf_pop;
   tbp_pkg::tbp_byte_t buf_data;
   tbp_pkg::tbp_byte_t next_byte;
   logic               next_marker;
   logic               next_alarm;
   logic [11:0]        aw_addr;
   logic               aw_got;
   logic [31:0]        w_data;
   logic [3:0]         w_strb;
   logic               w_got;
   logic               wr_do;
   logic [9:0]         wr_idx;
   logic               clr_underflow;

   // Overhead byte pattern for a given row and column
   function automatic tbp_pkg::tbp_byte_t toh_byte(input tbp_pkg::tbp_row_t r,
                                                   input tbp_pkg::tbp_col_t c);
      tbp_pkg::tbp_byte_t b;
      b = 8'h00;
      if (r == 4'h0) begin
         if (c < `TBP_A2_COL) begin
            b = `TBP_A1_BYTE;
         end else if (c < `TBP_J0_COL) begin
            b = `TBP_A2_BYTE;
         end else if (c == `TBP_J0_COL) begin
            b = `TBP_J0_BYTE;
         end
      end
      return b;
   endfunction

   // Parity over data, optionally widened by flag and marker
   function automatic logic parity(input tbp_pkg::tbp_byte_t d, input logic pl, input logic mk,
                                   input logic odd, input logic wide);
      logic p;
      p = ^d ^ (wide & (pl ^ mk));
      return p ^ odd;
   endfunction

   // Register index decode, used by both bus paths
   function automatic logic mapped(input logic [9:0] idx);
      return (idx == `TBP_IDX_SYNC_DLY) || (idx == `TBP_IDX_CTRL) || (idx == `TBP_IDX_STATUS);
   endfunction

   assign port_en     = bus_port_control[`TBP_CTRL_ENABLE];
   assign rephase_disabled_mode = bus_port_control[`TBP_CTRL_REPHASE_DIS];
   // A byte is launched on the cycle that raises the bus clock
   assign bus_rise    = port_en & ~tx_bus_clock_o;  // [R1] [R2]
   assign is_toh      = (col < `TBP_TOH_COLS);
   assign is_c1       = (row == 4'h0) && (col == `TBP_J0_COL);
   assign is_j1       = (row == `TBP_J1_ROW) && (col >= `TBP_TOH_COLS) && (col <= `TBP_J1_COL_LAST);
   // A restart sends an A1 in place of the slot, so the buffered byte must wait
   assign buf_pop     = bus_rise & ~is_toh & buf_valid & ~restart;
   assign sync_edge   = sync_ff2 & ~sync_last;
   assign restart     = bus_rise & sync_pend & (dly_cnt == 8'h00);

   always_comb begin
      next_byte   = is_toh ? toh_byte(row, col) : (buf_valid ? buf_data : 8'h00);
      next_marker = port_en & rephase_disabled_mode & (is_c1 | is_j1);  // [R3] [R4] [R5] [R17]
      next_alarm  = port_en & rephase_disabled_mode &
                    bus_port_control[`TBP_CTRL_AIS_LSB + 32'(slot)] & ~is_toh;  // [R6] [R7] [R17]
   end

   tbp_two_buf u_buf (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .s_valid_i (pay_valid_i),
      .s_ready_o (pay_ready_o),
      .s_data_i  (pay_data_i),
      .m_valid_o (buf_valid),
      .m_ready_i (buf_pop),
      .m_data_o  (buf_data)
   );

   // Bus clock: divided from clk_i, idle low while the port is off
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tx_bus_clock_o <= 1'b0;
      end else begin
         tx_bus_clock_o <= port_en & ~tx_bus_clock_o;  // [R1]
      end
   end

   // Sync pin synchroniser and edge memory
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync_ff1  <= 1'b0;
         sync_ff2  <= 1'b0;
         sync_last <= 1'b0;
      end else begin
         sync_ff1  <= tx_frame_sync_in_i;
         sync_ff2  <= sync_ff1;
         sync_last <= sync_ff2;
      end
   end

   // Delay from sync edge to frame start, counted in bus bytes
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync_pend <= 1'b0;
         dly_cnt   <= 8'h00;
      end else if (sync_edge && bus_port_control[`TBP_CTRL_EXT_SYNC] && port_en) begin
         sync_pend <= 1'b1;  // [R10]
         dly_cnt   <= frame_sync_delay_setting;  // [R14]
      end else if (bus_rise && sync_pend) begin
         if (dly_cnt == 8'h00) begin
            sync_pend <= 1'b0;
         end else begin
            dly_cnt <= dly_cnt - 8'h01;
         end
      end
   end

   // Frame position; free-running unless a sync restart arrives
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !port_en) begin
         row  <= 4'h0;
         col  <= 9'h000;
         slot <= 2'h0;
      end else if (restart) begin
         row  <= 4'h0;  // [R10]
         col  <= 9'h001;
         slot <= 2'h1;
      end else if (bus_rise) begin
         slot <= (slot == `TBP_SLOTS - 2'h1) ? 2'h0 : slot + 2'h1;  // [R11]
         if (col == `TBP_COLS - 9'h001) begin
            col <= 9'h000;
            row <= (row == `TBP_ROWS - 4'h1) ? 4'h0 : row + 4'h1;
         end else begin
            col <= col + 9'h001;
         end
      end
   end

   // Bus outputs, all updated together at the bus clock rise
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !port_en) begin
         tx_bus_byte_o        <= 8'h00;
         tx_payload_flag_o    <= 1'b0;
         tx_phase_marker_o    <= 1'b0;  // [R17]
         tx_path_alarm_flag_o <= 1'b0;
         tx_bus_parity_o      <= 1'b0;
      end else if (bus_rise) begin
         // The restart byte is the frame's first, so it is an A1
         tx_bus_byte_o        <= restart ? `TBP_A1_BYTE : next_byte;  // [R16] [R2]
         tx_payload_flag_o    <= restart ? 1'b0 : ~is_toh;  // [R15]
         tx_phase_marker_o    <= restart ? 1'b0 : next_marker;  // [R3] [R4]
         tx_path_alarm_flag_o <= restart ? 1'b0 : next_alarm;  // [R6]
         tx_bus_parity_o      <= restart ?
            parity(`TBP_A1_BYTE, 1'b0, 1'b0, bus_port_control[`TBP_CTRL_PAR_ODD],
                   bus_port_control[`TBP_CTRL_PAR_WIDE]) :
            parity(next_byte, ~is_toh, next_marker, bus_port_control[`TBP_CTRL_PAR_ODD],
                   bus_port_control[`TBP_CTRL_PAR_WIDE]);  // [R8] [R9]
      end
   end

   // Underflow: a payload slot found the buffer empty; set wins over clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         underflow <= 1'b0;
      end else begin
         underflow <= (underflow & ~clr_underflow) | (bus_rise & ~is_toh & ~buf_valid & ~restart);
      end
   end

   // AXI write path: address and data taken in either order
   assign wr_do         = aw_got & w_got & ~s_axi_bvalid_o;
   assign wr_idx        = aw_addr[11:2];
   assign clr_underflow = wr_do && (wr_idx == `TBP_IDX_STATUS) && w_strb[0] && w_data[`TBP_STAT_UNDERFLOW];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         aw_addr         <= 12'h000;
         aw_got          <= 1'b0;
         w_data          <= 32'h0000_0000;
         w_strb          <= 4'h0;
         w_got           <= 1'b0;
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `TBP_RESP_OKAY;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_addr         <= s_axi_awaddr_i;
            aw_got          <= 1'b1;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
            w_got          <= 1'b1;
            s_axi_wready_o <= 1'b0;
         end
         if (wr_do) begin
            aw_got         <= 1'b0;
            w_got          <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= mapped(wr_idx) ? `TBP_RESP_OKAY : `TBP_RESP_SLVERR;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   // Register storage; only byte lane 0 carries data
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         frame_sync_delay_setting <= `TBP_SYNC_DLY_RESET;
         bus_port_control         <= `TBP_CTRL_RESET;
      end else if (wr_do && w_strb[0]) begin
         if (wr_idx == `TBP_IDX_SYNC_DLY) begin
            frame_sync_delay_setting <= w_data[7:0];  // [R14]
         end
         if (wr_idx == `TBP_IDX_CTRL) begin
            bus_port_control <= w_data[7:0];  // [R9]
         end
      end
   end

   // AXI read path
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= `TBP_RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rresp_o   <= mapped(s_axi_araddr_i[11:2]) ? `TBP_RESP_OKAY : `TBP_RESP_SLVERR;
         unique case (s_axi_araddr_i[11:2])
            `TBP_IDX_SYNC_DLY: s_axi_rdata_o <= {24'h00_0000, frame_sync_delay_setting};
            `TBP_IDX_CTRL:     s_axi_rdata_o <= {24'h00_0000, bus_port_control};
            `TBP_IDX_STATUS:   s_axi_rdata_o <= {7'h00, col, 4'h0, row, 7'h00, underflow};
            default:           s_axi_rdata_o <= 32'h0000_0000;
         endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end
endmodule

// ---- tbp_tx_bus_port_checker.sv ----
`timescale 1ns/1ps
`include "tbp_defines.svh"
module tbp_tx_bus_port_checker (
   // Clock and reset
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   // Register bus handshakes
   input wire logic               s_axi_awvalid_i,
   input wire logic               s_axi_awready_o,
   input wire logic               s_axi_wvalid_i,
   input wire logic               s_axi_wready_o,
   input wire logic [1:0]         s_axi_bresp_o,
   input wire logic               s_axi_bvalid_o,
   input wire logic               s_axi_bready_i,
   input wire logic               s_axi_arvalid_i,
   input wire logic               s_axi_arready_o,
   input wire logic               s_axi_rvalid_o,
   input wire logic               s_axi_rready_i,
   // Telecom bus
   input wire logic               tx_bus_clock_o,
   input wire tbp_pkg::tbp_byte_t tx_bus_byte_o,
   input wire logic               tx_payload_flag_o,
   input wire logic               tx_phase_marker_o,
   input wire logic               tx_path_alarm_flag_o,
   input wire logic               tx_bus_parity_o
);
   logic [11:0] bus;
   assign bus = {tx_bus_byte_o, tx_payload_flag_o, tx_phase_marker_o, tx_path_alarm_flag_o, tx_bus_parity_o};
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_clk_sq; $rose(tx_bus_clock_o) |=> !tx_bus_clock_o; endproperty
   a_clk_sq: assert property (p_clk_sq) else $error("bus clock high too long");
   // Only a running clock is judged; a disable may drop the outputs mid-period
   property p_hold; tx_bus_clock_o ##1 !tx_bus_clock_o ##1 tx_bus_clock_o |-> $past(bus) == $past(bus, 2); endproperty
   a_hold: assert property (p_hold) else $error("bus changed off the rising edge");
   property p_c1; tx_phase_marker_o && !tx_payload_flag_o |-> tx_bus_byte_o == `TBP_J0_BYTE; endproperty
   a_c1: assert property (p_c1) else $error("overhead marker off the frame byte");
   property p_c1_len; $rose(tx_phase_marker_o) && !tx_payload_flag_o |=> tx_phase_marker_o ##1 !tx_phase_marker_o; endproperty
   a_c1_len: assert property (p_c1_len) else $error("overhead marker not one bus period");
   property p_al_pl; tx_path_alarm_flag_o |-> tx_payload_flag_o; endproperty
   a_al_pl: assert property (p_al_pl) else $error("alarm on an overhead byte");
   property p_b_ans; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o; endproperty
   a_b_ans: assert property (p_b_ans) else $error("write response late");
   property p_aw_blk; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
   a_aw_blk: assert property (p_aw_blk) else $error("write taken during response");
   property p_b_drop;
      s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o && s_axi_wready_o;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("write response not released");
   property p_r_ans; s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read data late");
   property p_r_drop; s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o; endproperty
   a_r_drop: assert property (p_r_drop) else $error("read data not released");
   c_j1: cover property (tx_phase_marker_o && tx_payload_flag_o);
   c_alarm: cover property (tx_path_alarm_flag_o);
   c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == `TBP_RESP_SLVERR);
endmodule

// ---- tbp_tx_bus_port_tb_top.sv ----
`timescale 1ns/1ps
`include "tbp_defines.svh"
module tbp_tx_bus_port_tb_top;
   logic               clk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready, sync_in, src_on, pay_valid;
   logic               awready, wready, bvalid, arready, rvalid, pl, mk, al, par, bclk, pay_ready, stb;
   logic [11:0]        awaddr, araddr, cap;
   logic [31:0]        wdata, rdata, d;
   logic [1:0]         bresp, rresp, r;
   logic [3:0]         wstrb;
   logic [15:0]        idx;
   tbp_pkg::tbp_byte_t pay_data, tbyte;
   tbp_pkg::tbp_byte_t q[$];
   logic [7:0]         modes [5] = '{8'h43, 8'h47, 8'h4B, 8'hAF, 8'h09};
   int                 miscompares, n_compared, cycles, n, n0;
   tbp_tx_bus_port uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pay_data_i(pay_data),
      .pay_valid_i(pay_valid), .pay_ready_o(pay_ready), .tx_frame_sync_in_i(sync_in), .tx_bus_clock_o(bclk),
      .tx_bus_byte_o(tbyte), .tx_payload_flag_o(pl), .tx_phase_marker_o(mk), .tx_path_alarm_flag_o(al),
      .tx_bus_parity_o(par));
   tbp_bus_sink sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_clock_i(bclk), .bus_i({tbyte, pl, mk, al, par}),
      .stb_o(stb), .idx_o(idx), .cap_o(cap));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Source never withdraws a byte it offered, so a stall loses nothing
   always @(posedge clk_i) begin
      if (pay_valid && pay_ready) begin
         q.push_back(pay_data);
         pay_data <= pay_data + 8'h01;
      end
      pay_valid <= src_on || (pay_valid && !pay_ready);
      cycles = cycles + 1;
      if (cycles == 60000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] i, input logic [31:0] v, input logic [1:0] er);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      @(posedge clk_i);
      awaddr <= {i, 2'b00};
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(a && w)) begin
         @(posedge clk_i);
         if (awvalid && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_i); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask
   task automatic rd(input logic [9:0] i);
      @(posedge clk_i);
      araddr <= {i, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_i); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_i); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   task automatic nxt;
      do @(posedge clk_i); while (stb !== 1'b1);
   endtask
   // Stops early in the next frame's overhead so no payload byte goes unaccounted at disable
   task automatic frame(input logic [7:0] m);
      int row, col;
      logic p, k, a;
      tbp_pkg::tbp_byte_t b;
      do begin
         nxt();
         row = (idx / `TBP_COLS) % `TBP_ROWS;
         col = idx % `TBP_COLS;
         p = (col >= `TBP_TOH_COLS);
         k = m[0] && m[1] && ((row == 0 && col == 6) || (row == 3 && col >= 9 && col <= 11));
         a = m[0] && m[1] && p && m[5 + col % 3];
         if (p) b = (q.size() > 0) ? q.pop_front() : 8'h00;
         else if (row == 0 && col < 7) b = (col < 3) ? `TBP_A1_BYTE : (col < 6) ? `TBP_A2_BYTE : `TBP_J0_BYTE;
         else b = 8'h00;
         chk("bus", {b, p, k, a, ^b ^ (m[3] && (p ^ k)) ^ m[2]}, cap);
      end while (idx != 16'd2430);
   endtask
   task automatic summarize;
      if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      {rst_n_i, awvalid, wvalid, bready, arvalid, rready, sync_in, src_on, pay_valid} = 9'h000;
      {awaddr, araddr, wdata, pay_data} = 64'h0000_0000_0000_0000;
      wstrb = 4'hF;
      {miscompares, n_compared, cycles} = {32'd0, 32'd0, 32'd0};
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(`TBP_IDX_CTRL);
      chk("ctrl reset", `TBP_CTRL_RESET, d);
      rd(`TBP_IDX_SYNC_DLY);
      chk("delay reset", `TBP_SYNC_DLY_RESET, d);
      rd(`TBP_IDX_STATUS);
      chk("status reset", 0, d & 32'h0000_0001);
      rd(10'h100);
      chk("unmapped rresp", `TBP_RESP_SLVERR, r);
      wr(10'h100, 32'h0000_00FF, `TBP_RESP_SLVERR);
      wr(`TBP_IDX_SYNC_DLY, 32'h0000_005A, `TBP_RESP_OKAY);
      rd(`TBP_IDX_SYNC_DLY);
      chk("delay rw", 32'h0000_005A, d);
      wstrb <= 4'hE;
      wr(`TBP_IDX_SYNC_DLY, 32'h0000_00A5, `TBP_RESP_OKAY);
      wstrb <= 4'hF;
      rd(`TBP_IDX_SYNC_DLY);
      chk("delay lane0 off", 32'h0000_005A, d);
      chk("idle bus", 0, {bclk, mk, al});
      src_on <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk("pay ready full", 0, pay_ready);
      for (int i = 0; i < 5; i++) begin
         if (i == 4) src_on <= 1'b0;
         wr(`TBP_IDX_CTRL, modes[i], `TBP_RESP_OKAY);
         rd(`TBP_IDX_CTRL);
         chk("ctrl", modes[i], d);
         frame(modes[i]);
         wr(`TBP_IDX_CTRL, 0, `TBP_RESP_OKAY);
      end
      rd(`TBP_IDX_STATUS);
      chk("underflow", 1, d & 32'h0000_0001);
      src_on <= 1'b1;
      wr(`TBP_IDX_STATUS, 32'h0000_0001, `TBP_RESP_OKAY);
      rd(`TBP_IDX_STATUS);
      chk("underflow clear", 0, d & 32'h0000_0001);
      for (int dl = 0; dl <= 5; dl += 5) begin
         wr(`TBP_IDX_CTRL, 0, `TBP_RESP_OKAY);
         wr(`TBP_IDX_SYNC_DLY, dl, `TBP_RESP_OKAY);
         wr(`TBP_IDX_CTRL, 32'h0000_0013, `TBP_RESP_OKAY);
         do nxt(); while (idx < 16'd20);
         n = 0;
         sync_in <= 1'b1;
         do begin
            nxt();
            if (n == 0) sync_in <= 1'b0;
            n++;
         end while (!(cap[2] && !cap[3]) && n < 200);
         if (dl == 0) n0 = n;
      end
      chk("sync start", 1, n0 >= 7 && n0 <= 10);
      chk("sync delay", n0 + 5, n);
      summarize();
   end
endmodule
bind tbp_tx_bus_port tbp_tx_bus_port_checker chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
   .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .tx_bus_clock_o(tx_bus_clock_o),
   .tx_bus_byte_o(tx_bus_byte_o), .tx_payload_flag_o(tx_payload_flag_o), .tx_phase_marker_o(tx_phase_marker_o),
   .tx_path_alarm_flag_o(tx_path_alarm_flag_o), .tx_bus_parity_o(tx_bus_parity_o));
